// ==== hw/station_address_select.sv ====
// Contract
// - Address word equals station number plus controller choice plus broadcast value.
// - Choice value 32 selects first controller, 64 second, both adds both.
// - Broadcast value 128 targets all stations, zero only the addressed one.
// - Only first select asserted: first controller answer goes to host.
// - Only second select asserted: second controller answer goes to host.
// - Both selects: both execute, only first controller answers.
// - Broadcast: chosen controllers everywhere execute; only matching station answers.
// - Transmitter enabled only while this station is selected.
// - Address-port controller always receives host commands regardless of selection.
// - After reset port decodes station zero, both selects deasserted.
// - Disable jumper bypasses selector while jumper_fitted is high: station non-addressable, single-station use.
// - Selected, receive and transmit indicators with flicker on data.
`include "station_address_select_params.svh"
`default_nettype none

module station_address_select
	import station_address_select_pkg::*;
#(
	parameter int unsigned FLICKER_CYCLES = `FLICKER_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] address_out_port,
	input  wire logic [4:0] station_id,
	input  wire logic       selector_disable,
	input  wire logic       jumper_fitted,
	input  wire logic       host_rx_data,
	input  wire logic       first_controller_tx,
	input  wire logic       second_controller_tx,
	output var  logic       first_ctrl_select,
	output var  logic       second_ctrl_select,
	output var  logic       broadcast_qualifier,
	output var  logic       first_controller_rx,
	output var  logic       second_controller_rx,
	output var  logic       address_port_controller_rx,
	output var  logic       host_tx_data,
	output var  logic       transmit_enable_isolator,
	output var  logic       station_selected,
	output var  logic       selected_indicator,
	output var  logic       receive_indicator,
	output var  logic       transmit_indicator
);

	// Field sizes kept beside their positions so a layout change is caught here
	localparam int unsigned STATION_W = `STATION_MSB - `STATION_LSB + 1;
	localparam int unsigned BLANK_W   = 28;

	if (FLICKER_CYCLES < 2 || FLICKER_CYCLES > (2 ** BLANK_W) - 1) begin : g_bad_flicker
		$error("FLICKER_CYCLES out of range");
	end
	if (STATION_W != 5 || `FIRST_SEL_BIT != `STATION_MSB + 1) begin : g_bad_layout
		$error("address word layout does not fit the decoder");
	end

	typedef enum logic [2:0] {
		MODE_DEAD      = 3'b001,
		MODE_SINGLE    = 3'b010,
		MODE_ADDRESSED = 3'b100
	} mode_type;

	typedef struct packed {
		// Pin synchroniser stages
		logic [7:0]  addr_s0;
		logic [7:0]  addr_s1;
		logic [7:0]  addr_s2;
		logic [4:0]  id_s0;
		logic [4:0]  id_s1;
		logic [4:0]  id_s2;
		logic [2:0]  rx_sync;
		logic [2:0]  u1_sync;
		logic [2:0]  u2_sync;
		logic [2:0]  dis_sync;
		logic [2:0]  jmp_sync;
		// Levels taken once two stages agree
		logic [7:0]  addr_word;
		logic [4:0]  id_word;
		logic        disable_lvl;
		logic        jumper_lvl;
		logic        rx_lvl;
		logic        u1_lvl;
		logic        u2_lvl;
		// Decode and routing
		route_type   route;
		logic        sel1;
		logic        sel2;
		logic        bcast;
		logic        selected;
		// Registered lines toward controllers and host
		logic        rx1;
		logic        rx2;
		logic        rx3;
		logic        tx;
		logic        tx_en;
		// Indicators and their blanking timers
		logic        sel_led;
		logic        rx_led;
		logic        tx_led;
		logic [BLANK_W-1:0] rx_blank;
		logic [BLANK_W-1:0] tx_blank;
	} state_type;

	state_type  state;
	state_type  next_state;
	logic [1:0] rst_sync;
	logic       rst_int_b;

	assign rst_int_b = rst_sync[1];

	// Reset release synchroniser runs on the raw asynchronous reset, so the
	// rest of the block always leaves reset on a clean clock edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge rst_int_b) begin
		if (!rst_int_b) begin
			state           <= '0;
			state.addr_word <= `ADDR_WORD_RESET;
			state.route     <= ROUTE_NONE;
		end else begin
			state <= next_state;
		end
	end

	logic [4:0] dec_station;
	logic       dec_first;
	logic       dec_second;
	logic       dec_bcast;
	logic       match;
	mode_type   mode;
	logic       rx_change;
	logic       tx_change;

	// Word is S + 32*first + 64*second + 128*broadcast; only the agreed copy is decoded
	always_comb begin
		dec_station = state.addr_word[`STATION_MSB:`STATION_LSB];
		dec_first   = state.addr_word[`FIRST_SEL_BIT];
		dec_second  = state.addr_word[`SECOND_SEL_BIT];
		dec_bcast   = state.addr_word[`BROADCAST_BIT];
		match       = (dec_station == state.id_word);
		if (!state.jumper_lvl) begin
			mode = MODE_DEAD;
		end else if (state.disable_lvl) begin
			mode = MODE_SINGLE;
		end else begin
			mode = MODE_ADDRESSED;
		end
	end

	always_comb begin
		next_state = state;

		// Three-stage pin synchronisers; only stages two and three are compared,
		// since the first stage may still be settling
		next_state.addr_s0  = address_out_port;
		next_state.addr_s1  = state.addr_s0;
		next_state.addr_s2  = state.addr_s1;

		next_state.id_s0    = station_id;
		next_state.id_s1    = state.id_s0;
		next_state.id_s2    = state.id_s1;

		next_state.rx_sync  = {state.rx_sync[1:0], host_rx_data};
		next_state.u1_sync  = {state.u1_sync[1:0], first_controller_tx};
		next_state.u2_sync  = {state.u2_sync[1:0], second_controller_tx};
		next_state.dis_sync = {state.dis_sync[1:0], selector_disable};
		next_state.jmp_sync = {state.jmp_sync[1:0], jumper_fitted};

		// A word is taken only when two stages agree, so a port caught half-way
		// through an update is never decoded
		if (state.addr_s1 == state.addr_s2) begin
			next_state.addr_word = state.addr_s2;
		end
		if (state.id_s1 == state.id_s2) begin
			next_state.id_word = state.id_s2;
		end

		if (state.rx_sync[1] == state.rx_sync[2]) begin
			next_state.rx_lvl = state.rx_sync[2];
		end

		if (state.u1_sync[1] == state.u1_sync[2]) begin
			next_state.u1_lvl = state.u1_sync[2];
		end

		if (state.u2_sync[1] == state.u2_sync[2]) begin
			next_state.u2_lvl = state.u2_sync[2];
		end

		if (state.dis_sync[1] == state.dis_sync[2]) begin
			next_state.disable_lvl = state.dis_sync[2];
		end

		if (state.jmp_sync[1] == state.jmp_sync[2]) begin
			next_state.jumper_lvl = state.jmp_sync[2];
		end

		case (mode)
			MODE_DEAD: begin
				// No jumper: station dead, neither executes nor answers
				next_state.sel1     = 1'b0;
				next_state.sel2     = 1'b0;
				next_state.bcast    = 1'b0;
				next_state.selected = 1'b0;
			end
			MODE_SINGLE: begin
				// Single-station use: both controllers always enabled, first answers
				next_state.sel1     = 1'b1;
				next_state.sel2     = 1'b1;
				next_state.bcast    = 1'b0;
				next_state.selected = 1'b1;
			end
			MODE_ADDRESSED: begin
				next_state.sel1     = dec_first & (match | dec_bcast);
				next_state.sel2     = dec_second & (match | dec_bcast);
				next_state.bcast    = dec_bcast;
				// Only the matching station may answer, even in broadcast
				next_state.selected = match & (dec_first | dec_second);
			end
			default: begin
				next_state.sel1     = 1'b0;
				next_state.sel2     = 1'b0;
				next_state.bcast    = 1'b0;
				next_state.selected = 1'b0;
			end
		endcase

		// Answer routing: first controller wins when both are selected
		if (next_state.selected && next_state.sel1) begin
			next_state.route = ROUTE_FIRST;
		end else if (next_state.selected && next_state.sel2) begin
			next_state.route = ROUTE_SECOND;
		end else begin
			next_state.route = ROUTE_NONE;
		end

		// Answer line idles at mark whenever no controller owns it
		case (state.route)
			ROUTE_FIRST: begin
				next_state.tx = state.u1_lvl;
			end
			ROUTE_SECOND: begin
				next_state.tx = state.u2_lvl;
			end
			ROUTE_NONE: begin
				next_state.tx = 1'b1;
			end
			default: begin
				next_state.tx = 1'b1;
			end
		endcase
		next_state.tx_en = state.route != ROUTE_NONE;

		// Deselected controllers see an idle line so they stay deaf
		next_state.rx1 = state.sel1 ? state.rx_lvl : 1'b1;
		next_state.rx2 = state.sel2 ? state.rx_lvl : 1'b1;
		next_state.rx3 = state.rx_lvl;

		// Receive and transmit indicators blink off briefly on each data edge so activity is visible
		rx_change = state.rx_sync[2] != state.rx_lvl;
		tx_change = state.tx != next_state.tx;
		if (rx_change) begin
			next_state.rx_blank = BLANK_W'(FLICKER_CYCLES - 1);
		end else if (state.rx_blank != '0) begin
			next_state.rx_blank = state.rx_blank - BLANK_W'(1);
		end

		if (tx_change && state.tx_en) begin
			next_state.tx_blank = BLANK_W'(FLICKER_CYCLES - 1);
		end else if (state.tx_blank != '0) begin
			next_state.tx_blank = state.tx_blank - BLANK_W'(1);
		end

		next_state.sel_led = state.selected;
		next_state.rx_led  = state.rx_blank == '0;
		next_state.tx_led  = state.tx_en && state.tx_blank == '0;
	end

	// Every output is a plain register bit, so no pin glitches while decoding
	assign first_ctrl_select          = state.sel1;
	assign second_ctrl_select         = state.sel2;
	assign broadcast_qualifier        = state.bcast;
	assign first_controller_rx        = state.rx1;
	assign second_controller_rx       = state.rx2;
	assign address_port_controller_rx = state.rx3;
	assign host_tx_data               = state.tx;
	assign transmit_enable_isolator   = state.tx_en;
	assign station_selected           = state.selected;
	assign selected_indicator         = state.sel_led;
	assign receive_indicator          = state.rx_led;
	assign transmit_indicator         = state.tx_led;

endmodule // station_address_select
`default_nettype wire

// ==== hw/station_address_select_params.svh ====
`ifndef STATION_ADDRESS_SELECT_PARAMS_SVH
`define STATION_ADDRESS_SELECT_PARAMS_SVH
// Address word layout
`define STATION_LSB          0
`define STATION_MSB          4
`define FIRST_SEL_BIT        5
`define SECOND_SEL_BIT       6
`define BROADCAST_BIT        7
`define ADDR_WORD_RESET      8'h00
`define STATION_ID_MAX       5'h1f
// Indicator flicker: blank time after each data edge
`define FLICKER_TIME_NS      20000000
`define CLK_PERIOD_NS        10
`define FLICKER_CYCLES       (`FLICKER_TIME_NS / `CLK_PERIOD_NS)
`endif

// ==== hw/station_address_select_pkg.sv ====
`default_nettype none
package station_address_select_pkg;
	typedef enum logic [2:0] {
		ROUTE_NONE   = 3'b001,
		ROUTE_FIRST  = 3'b010,
		ROUTE_SECOND = 3'b100
	} route_type;
endpackage
`default_nettype wire

// ==== verif/host_model.sv ====
`default_nettype none
module host_model (
	input  wire logic tx_en,
	input  wire logic tx_line,
	input  wire logic drive_bit,
	output var  logic rx_line,
	output var  logic seen
);
	timeunit 1ns;
	timeprecision 1ps;
	assign rx_line = drive_bit;
	// Termination pulls a released pair to mark, so a silent station reads idle
	assign seen = tx_en ? tx_line : 1'b1;
endmodule // host_model
`default_nettype wire

// ==== verif/station_address_select_properties.sv ====
`default_nettype none
module station_address_select_properties #(
	parameter int unsigned FLICKER_CYCLES = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic jumper_fitted,
	input wire logic host_rx_data,
	input wire logic first_controller_tx,
	input wire logic second_controller_tx,
	input wire logic first_ctrl_select,
	input wire logic second_ctrl_select,
	input wire logic first_controller_rx,
	input wire logic address_port_controller_rx,
	input wire logic host_tx_data,
	input wire logic transmit_enable_isolator,
	input wire logic station_selected,
	input wire logic transmit_indicator
);
	logic [3:0] up;
	logic       ok;
	// Pipelines refill after the synchronised reset lets go
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			up <= 4'h0;
		else if (up != 4'hf)
			up <= up + 4'h1;
	end
	assign ok = up == 4'hf;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence dead; (!jumper_fitted)[*8]; endsequence
	sequence first_low;
		ok ##0 (first_ctrl_select && station_selected && !first_controller_tx)[*8];
	endsequence
	sequence second_low;
		ok ##0 (second_ctrl_select && !first_ctrl_select && station_selected
			&& !second_controller_tx)[*8];
	endsequence
	a_tx_needs_sel: assert property (transmit_enable_isolator |-> $past(station_selected))
		else $error("transmitter on without selection");
	a_tx_idle: assert property (ok && !transmit_enable_isolator |-> host_tx_data)
		else $error("answer line not idle while disabled");
	a_no_jumper: assert property (dead |=> !first_ctrl_select && !second_ctrl_select)
		else $error("select without jumper");
	a_rx_gated: assert property (ok ##0 (!first_ctrl_select)[*6] |-> first_controller_rx)
		else $error("deselected controller hears data");
	a_apc_follows: assert property (ok ##0 (!host_rx_data)[*8] |-> !address_port_controller_rx)
		else $error("address controller not tracking host");
	a_first_route: assert property (first_low |-> !host_tx_data)
		else $error("first answer not routed");
	a_second_route: assert property (second_low |-> !host_tx_data)
		else $error("second answer not routed");
	a_sel_has_ctrl: assert property (station_selected |-> first_ctrl_select || second_ctrl_select)
		else $error("selected without controller");
	a_tx_led: assert property (transmit_indicator |->
		transmit_enable_isolator || $past(transmit_enable_isolator))
		else $error("transmit indicator without transmitter");
endmodule // station_address_select_properties
bind station_address_select station_address_select_properties #(
	.FLICKER_CYCLES(FLICKER_CYCLES)) u_props (.clk, .rst_b, .jumper_fitted, .host_rx_data,
	.first_controller_tx, .second_controller_tx, .first_ctrl_select, .second_ctrl_select,
	.first_controller_rx, .address_port_controller_rx, .host_tx_data,
	.transmit_enable_isolator, .station_selected, .transmit_indicator);
`default_nettype wire

// ==== verif/station_address_select_tb.sv ====
`default_nettype none
module station_address_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [4:0]  id = 5'h00;
	logic        dis = 1'b0, jmp = 1'b1, hbit = 1'b1, f_tx = 1'b1, s_tx = 1'b1;
	logic        f_sel, s_sel, brd, f_rx, s_rx, a_rx, h_tx, tx_en, sel, h_rx, seen;
	logic        sel_led, rx_led, tx_led;
	logic [21:0] rows [10];
	int          error_cnt = 0;
	int          n_checks = 0;
	initial forever #5 clk = ~clk;
	station_address_select #(.FLICKER_CYCLES(4)) dut (.clk, .rst_b, .address_out_port(addr),
		.station_id(id), .selector_disable(dis), .jumper_fitted(jmp), .host_rx_data(h_rx),
		.first_controller_tx(f_tx), .second_controller_tx(s_tx), .first_ctrl_select(f_sel),
		.second_ctrl_select(s_sel), .broadcast_qualifier(brd), .first_controller_rx(f_rx),
		.second_controller_rx(s_rx), .address_port_controller_rx(a_rx),
		.host_tx_data(h_tx), .transmit_enable_isolator(tx_en), .station_selected(sel),
		.selected_indicator(sel_led), .receive_indicator(rx_led),
		.transmit_indicator(tx_led));
	host_model host (.tx_en, .tx_line(h_tx), .drive_bit(hbit), .rx_line(h_rx), .seen);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		// Address, station, disable, jumper, {first, second, broadcast, selected, tx}, route
		rows = '{{8'h25, 5'h05, 1'h0, 1'h1, 5'h13, 2'h1}, {8'h45, 5'h05, 1'h0, 1'h1, 5'h0b, 2'h2},
			{8'h65, 5'h05, 1'h0, 1'h1, 5'h1b, 2'h1}, {8'ha3, 5'h05, 1'h0, 1'h1, 5'h14, 2'h0},
			{8'he5, 5'h05, 1'h0, 1'h1, 5'h1f, 2'h1}, {8'h3f, 5'h1f, 1'h0, 1'h1, 5'h13, 2'h1},
			{8'h45, 5'h06, 1'h0, 1'h1, 5'h00, 2'h0}, {8'hc5, 5'h06, 1'h0, 1'h1, 5'h0c, 2'h0},
			{8'h25, 5'h05, 1'h0, 1'h0, 5'h00, 2'h0}, {8'h00, 5'h09, 1'h1, 1'h1, 5'h1b, 2'h1}};
		repeat (3) @(posedge clk);
		@(negedge clk) rst_b = 1'b1;
		repeat (12) @(negedge clk);
		chk({f_sel, s_sel, sel, tx_en}, 8'h00);
		foreach (rows[i]) begin
			{addr, id, dis, jmp} = rows[i][21:7];
			{hbit, f_tx, s_tx} = 3'b001;
			repeat (6) @(negedge clk);
			chk(rx_led, 1'b0);
			repeat (8) @(negedge clk);
			chk({f_sel, s_sel, brd, sel, tx_en}, rows[i][6:2]);
			chk({f_rx, s_rx, a_rx}, {~rows[i][6], ~rows[i][5], 1'b0});
			chk(seen, rows[i][1:0] != 2'h1);
			{hbit, f_tx, s_tx} = 3'b110;
			repeat (14) @(negedge clk);
			chk(seen, rows[i][1:0] != 2'h2);
			{hbit, f_tx, s_tx} = 3'b111;
			repeat (14) @(negedge clk);
			chk({sel_led, rx_led, tx_led}, {rows[i][3], 1'b1, rows[i][2]});
		end
		print_verdict();
	end
endmodule // station_address_select_tb
`default_nettype wire
